// [design/imc_pkg.sv]
// Shared constants, field layout and types of the interrupt mode control block.
package imc_pkg;
  localparam int NUM_REGS = 8;
  localparam int NUM_CAP = 4;
  localparam int FIRST_CAP = 4;
  localparam int ADDR_W = 6;
  localparam int BYTE_SHIFT = 2;

  localparam logic [31:0] OFS_SRC80 = 32'hffffd050;
  localparam logic [31:0] OFS_SRC81 = 32'hffffd051;
  localparam logic [31:0] OFS_SRC82 = 32'hffffd052;
  localparam logic [31:0] OFS_SRC83 = 32'hffffd053;
  localparam logic [31:0] OFS_CAP_A0 = 32'hffffd054;
  localparam logic [31:0] OFS_CAP_A1 = 32'hffffd055;
  localparam logic [31:0] OFS_CAP_B0 = 32'hffffd056;
  localparam logic [31:0] OFS_CAP_B1 = 32'hffffd057;
  localparam logic [31:0] REG_OFS [NUM_REGS] = '{OFS_SRC80, OFS_SRC81, OFS_SRC82, OFS_SRC83,
                                                 OFS_CAP_A0, OFS_CAP_A1, OFS_CAP_B0, OFS_CAP_B1};

  localparam logic [ADDR_W-1:0] ADDR_STATUS = 6'h20;

  localparam int SENS_LSB = 5;
  localparam int SENS_MSB = 6;
  localparam int DMA_BIT = 4;
  localparam int LVL_MSB = 2;
  localparam int LVL_LSB = 0;
  localparam logic [7:0] CTRL_WR_MASK = 8'h77;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [2:0] LEVEL_OFF = 3'h0;

  localparam int STAT_PEND_LSB = 0;
  localparam int STAT_IRQ_LSB = 4;
  localparam int STAT_DMA_LSB = 8;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  localparam logic [3:0] SLOT_STATUS = 4'h8;
  localparam logic [3:0] SLOT_MISS = 4'hf;

  typedef enum logic [1:0] {
    SENS_LOW = 2'h0,
    SENS_HIGH = 2'h1,
    SENS_RISE = 2'h2,
    SENS_FALL = 2'h3
  } imc_sens_t;

  typedef enum logic [1:0] {
    WR_IDLE = 2'h0,
    WR_ADDR = 2'h1,
    WR_RESP = 2'h3,
    WR_DATA = 2'h2
  } imc_wr_state_t;

  typedef enum logic {
    RD_IDLE = 1'h0,
    RD_DATA = 1'h1
  } imc_rd_state_t;

  // The printed offsets are word-granular, so each becomes a byte address from the block base.
  function automatic logic [ADDR_W-1:0] regByteAddr(input logic [31:0] printed);
    logic [31:0] idx;
    idx = printed - OFS_SRC80;
    return ADDR_W'(idx << BYTE_SHIFT);
  endfunction
endpackage

// [design/imc_src_if.sv]
// Per-source bundle between the register block, the edge detector and the router.
interface imc_src_if;
  imc_pkg::imc_sens_t sens;
  logic dmaEn;
  logic [2:0] levelChan;
  logic capEvent;
  logic hit;
  logic irqHit;
  logic dmaHit;

  modport top (
    output sens,
    output dmaEn,
    output levelChan,
    output capEvent,
    input irqHit,
    input dmaHit
  );

  modport det (
    input sens,
    input capEvent,
    output hit
  );

  modport route (
    input dmaEn,
    input levelChan,
    input hit,
    output irqHit,
    output dmaHit
  );
endinterface

// [design/imc_edge_det.sv]
// Sensitivity detector for one capture event source.
module imc_edge_det (
  input wire logic mclk,
  input wire logic rst,
  imc_src_if.det src
);
  logic prevEvent;

  always_ff @(posedge mclk) begin
    if (rst) begin
      prevEvent <= 1'b0;
    end else begin
      prevEvent <= src.capEvent;
    end
  end

  // Events come from timer logic on the same clock, so no synchroniser is placed here.
  always_comb begin
    case (src.sens)
      imc_pkg::SENS_LOW: begin
        src.hit = ~src.capEvent;
      end
      imc_pkg::SENS_HIGH: begin
        src.hit = src.capEvent;
      end
      imc_pkg::SENS_RISE: begin
        src.hit = src.capEvent & ~prevEvent;
      end
      imc_pkg::SENS_FALL: begin
        src.hit = ~src.capEvent & prevEvent;
      end
      default: begin
        src.hit = 1'b0;
      end
    endcase
  end
endmodule

// [design/imc_route.sv]
// Steers one detected request to the CPU interrupt path or to a DMA trigger.
module imc_route (
  imc_src_if.route src
);
  always_comb begin
    src.irqHit = src.hit & ~src.dmaEn & (src.levelChan != imc_pkg::LEVEL_OFF);
    src.dmaHit = src.hit & src.dmaEn;
  end
endmodule

// [design/imc_mode_ctrl.sv]
// Interrupt mode control for sources 80 to 87 with an AXI4-Lite register slave.
//
// Implementation choice: the AXI4-Lite register port.
module imc_mode_ctrl (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [5:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [3:0] capEvent,
  input wire logic [3:0] intAck,
  output logic [3:0] irqPending,
  output logic [3:0][2:0] irqLevel,
  output logic [3:0] dmaTrig,
  output logic [3:0][2:0] dmaChan
);
  logic [7:0] ctrlByte [imc_pkg::NUM_REGS];
  imc_pkg::imc_wr_state_t wrState;
  imc_pkg::imc_wr_state_t next_wrState;
  imc_pkg::imc_rd_state_t rdState;
  logic [5:0] awAddrQ;
  logic [31:0] wDataQ;
  logic [3:0] wStrbQ;
  logic [5:0] wrAddr;
  logic [31:0] wrData;
  logic [3:0] wrStrb;
  logic awTaken;
  logic wTaken;
  logic doWrite;
  logic [3:0] wrSlot;
  logic [3:0] rdSlot;
  logic [31:0] rdWord;
  logic [3:0] capIrqHit;
  logic [3:0] capDmaHit;
  logic [3:0] irqRouted;
  logic [3:0] dmaRouted;
  logic [31:0] statusWord;

  function automatic logic [3:0] decodeSlot(input logic [5:0] addr);
    logic [3:0] slot;
    slot = imc_pkg::SLOT_MISS;
    for (int i = 0; i < imc_pkg::NUM_REGS; i++) begin
      if (addr == imc_pkg::regByteAddr(imc_pkg::REG_OFS[i])) begin
        slot = 4'(i);
      end
    end
    if (addr == imc_pkg::ADDR_STATUS) begin
      slot = imc_pkg::SLOT_STATUS;
    end
    return slot;
  endfunction

  function automatic logic [7:0] ctrlView(input logic [7:0] raw);
    return raw & imc_pkg::CTRL_WR_MASK;
  endfunction

  // Address and data may arrive in either order; the write lands when the second is taken.
  assign s_axi_awready = (wrState == imc_pkg::WR_IDLE) || (wrState == imc_pkg::WR_DATA);
  assign s_axi_wready = (wrState == imc_pkg::WR_IDLE) || (wrState == imc_pkg::WR_ADDR);
  assign s_axi_bvalid = (wrState == imc_pkg::WR_RESP);
  assign awTaken = s_axi_awvalid && s_axi_awready;
  assign wTaken = s_axi_wvalid && s_axi_wready;

  always_comb begin
    next_wrState = wrState;
    doWrite = 1'b0;
    case (wrState)
      imc_pkg::WR_IDLE: begin
        if (awTaken && wTaken) begin
          next_wrState = imc_pkg::WR_RESP;
          doWrite = 1'b1;
        end else if (awTaken) begin
          next_wrState = imc_pkg::WR_ADDR;
        end else if (wTaken) begin
          next_wrState = imc_pkg::WR_DATA;
        end
      end
      imc_pkg::WR_ADDR: begin
        if (wTaken) begin
          next_wrState = imc_pkg::WR_RESP;
          doWrite = 1'b1;
        end
      end
      imc_pkg::WR_DATA: begin
        if (awTaken) begin
          next_wrState = imc_pkg::WR_RESP;
          doWrite = 1'b1;
        end
      end
      imc_pkg::WR_RESP: begin
        if (s_axi_bready) begin
          next_wrState = imc_pkg::WR_IDLE;
        end
      end
      default: begin
        next_wrState = imc_pkg::WR_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      wrState <= imc_pkg::WR_IDLE;
    end else begin
      wrState <= next_wrState;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      awAddrQ <= 6'h00;
    end else if (awTaken) begin
      awAddrQ <= s_axi_awaddr;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      wDataQ <= 32'h00000000;
      wStrbQ <= 4'h0;
    end else if (wTaken) begin
      wDataQ <= s_axi_wdata;
      wStrbQ <= s_axi_wstrb;
    end
  end

  always_comb begin
    wrAddr = (wrState == imc_pkg::WR_ADDR) ? awAddrQ : s_axi_awaddr;
    wrData = (wrState == imc_pkg::WR_DATA) ? wDataQ : s_axi_wdata;
    wrStrb = (wrState == imc_pkg::WR_DATA) ? wStrbQ : s_axi_wstrb;
    wrSlot = decodeSlot(wrAddr);
  end

  // An unmapped write is dropped and answered with a decode error.
  always_ff @(posedge mclk) begin
    if (rst) begin
      s_axi_bresp <= imc_pkg::RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bresp <= (wrSlot == imc_pkg::SLOT_MISS) ? imc_pkg::RESP_DECERR : imc_pkg::RESP_OKAY;
    end
  end

  // Each control byte sits in lane zero of its own word.
  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int i = 0; i < imc_pkg::NUM_REGS; i++) begin
        ctrlByte[i] <= imc_pkg::CTRL_RESET;
      end
    end else if (doWrite && wrStrb[0] && (wrSlot < imc_pkg::SLOT_STATUS)) begin
      ctrlByte[wrSlot[2:0]] <= wrData[7:0] & imc_pkg::CTRL_WR_MASK;
    end
  end

  assign s_axi_arready = (rdState == imc_pkg::RD_IDLE);
  assign s_axi_rvalid = (rdState == imc_pkg::RD_DATA);

  always_ff @(posedge mclk) begin
    if (rst) begin
      rdState <= imc_pkg::RD_IDLE;
    end else begin
      case (rdState)
        imc_pkg::RD_IDLE: begin
          if (s_axi_arvalid) begin
            rdState <= imc_pkg::RD_DATA;
          end
        end
        imc_pkg::RD_DATA: begin
          if (s_axi_rready) begin
            rdState <= imc_pkg::RD_IDLE;
          end
        end
        default: begin
          rdState <= imc_pkg::RD_IDLE;
        end
      endcase
    end
  end

  always_comb begin
    statusWord = 32'h00000000;
    statusWord[imc_pkg::STAT_PEND_LSB +: imc_pkg::NUM_CAP] = irqPending;
    statusWord[imc_pkg::STAT_IRQ_LSB +: imc_pkg::NUM_CAP] = irqRouted;
    statusWord[imc_pkg::STAT_DMA_LSB +: imc_pkg::NUM_CAP] = dmaRouted;
  end

  always_comb begin
    rdSlot = decodeSlot(s_axi_araddr);
    rdWord = 32'h00000000;
    if (rdSlot == imc_pkg::SLOT_STATUS) begin
      rdWord = statusWord;
    end else if (rdSlot != imc_pkg::SLOT_MISS) begin
      rdWord[7:0] = ctrlView(ctrlByte[rdSlot[2:0]]);
    end
  end

  // Read data is captured at the address edge, so it stays steady while rvalid waits.
  always_ff @(posedge mclk) begin
    if (rst) begin
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= imc_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rdata <= rdWord;
      s_axi_rresp <= (rdSlot == imc_pkg::SLOT_MISS) ? imc_pkg::RESP_DECERR : imc_pkg::RESP_OKAY;
    end
  end

  // Reserved bytes for sources 80 to 83 are stored but drive no request path.
  genvar g;
  generate
    for (g = 0; g < imc_pkg::NUM_CAP; g++) begin : gCap
      imc_src_if srcBus ();

      assign srcBus.capEvent = capEvent[g];
      assign srcBus.sens = imc_pkg::imc_sens_t'(
        ctrlByte[imc_pkg::FIRST_CAP + g][imc_pkg::SENS_MSB:imc_pkg::SENS_LSB]);
      assign srcBus.dmaEn = ctrlByte[imc_pkg::FIRST_CAP + g][imc_pkg::DMA_BIT];
      assign srcBus.levelChan = ctrlByte[imc_pkg::FIRST_CAP + g][imc_pkg::LVL_MSB:imc_pkg::LVL_LSB];
      assign capIrqHit[g] = srcBus.irqHit;
      assign capDmaHit[g] = srcBus.dmaHit;
      assign irqRouted[g] = ~srcBus.dmaEn && (srcBus.levelChan != imc_pkg::LEVEL_OFF);
      assign dmaRouted[g] = srcBus.dmaEn;

      imc_edge_det uDet (
        .mclk(mclk),
        .rst(rst),
        .src(srcBus)
      );

      imc_route uRoute (
        .src(srcBus)
      );

      always_ff @(posedge mclk) begin
        if (rst) begin
          irqPending[g] <= 1'b0;
        end else if (capIrqHit[g]) begin
          irqPending[g] <= 1'b1;
        end else if (intAck[g] || !irqRouted[g]) begin
          irqPending[g] <= 1'b0;
        end
      end

      always_ff @(posedge mclk) begin
        if (rst) begin
          irqLevel[g] <= imc_pkg::LEVEL_OFF;
        end else if (srcBus.dmaEn) begin
          irqLevel[g] <= imc_pkg::LEVEL_OFF;
        end else begin
          irqLevel[g] <= srcBus.levelChan;
        end
      end

      always_ff @(posedge mclk) begin
        if (rst) begin
          dmaTrig[g] <= 1'b0;
          dmaChan[g] <= 3'h0;
        end else begin
          dmaTrig[g] <= capDmaHit[g];
          if (capDmaHit[g]) begin
            dmaChan[g] <= srcBus.levelChan;
          end
        end
      end
    end
  endgenerate
endmodule

// [verification/imc_mode_ctrl_props.sv]
// Checker of the bus handshakes and routing outputs of the mode control block.
module imc_mode_ctrl_props (
  input wire logic mclk,
  input wire logic rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [3:0] irqPending,
  input wire logic [3:0][2:0] irqLevel,
  input wire logic [3:0] dmaTrig
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  a_reset_clear: assert property ($fell(rst) |->
    irqPending == 4'h0 && dmaTrig == 4'h0 && irqLevel == 12'h000) else $error("outputs not clear");
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
    else $error("write not answered");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_bresp_stands: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rdata_stands: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:12] == 20'h0)
    else $error("upper read bits set");
  a_busy_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
  for (genvar i = 0; i < 4; i++) begin : g_src
    a_pend_level: assert property ($rose(irqPending[i]) |-> irqLevel[i] != 3'h0)
      else $error("pending with level zero");
    a_trig_level: assert property (dmaTrig[i] |-> irqLevel[i] == 3'h0)
      else $error("trigger with priority shown");
  end
endmodule

bind imc_mode_ctrl imc_mode_ctrl_props u_props (.mclk, .rst, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .irqPending, .irqLevel, .dmaTrig);

// [verification/imc_cap_model.sv]
// Model of the capture sources, the interrupt acknowledge and the DMA side.
module imc_cap_model (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [3:0] fire,
  input wire logic ackEn,
  input wire logic [3:0] irqPending,
  input wire logic [3:0] dmaTrig,
  output logic [3:0] capEvent,
  output logic [3:0] intAck,
  output int trigCnt
);
  initial begin
    capEvent = 4'h0;
    intAck = 4'h0;
    trigCnt = 0;
  end
  // clean rising events
  // Events are registered so each one starts on a clock edge, source 84 at bit 0.
  always @(posedge mclk) begin
    capEvent <= rst ? 4'h0 : fire;
    intAck <= rst ? 4'h0 : irqPending & {4{ackEn}};
    trigCnt <= rst ? 0 : trigCnt + $countones(dmaTrig);
  end
endmodule

// [verification/imc_mode_ctrl_tb.sv]
// Self-checking bench of the interrupt mode control block.
module imc_mode_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {int s; logic [7:0] d; logic pend; logic [2:0] lvl; int trig; logic [2:0] ch;} imc_row_t;
  logic mclk = 0, rst = 1, ackEn = 0;
  logic [5:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 0, capEvent, intAck, irqPending, dmaTrig, fire = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [3:0][2:0] irqLevel, dmaChan;
  int trigCnt, c, err_total = 0, tests_run = 0;
  imc_row_t r;
  imc_row_t rows[8] = '{'{3, 8'h63, 1, 3'h3, 0, 3'h0}, '{1, 8'h22, 1, 3'h2, 0, 3'h0},
    '{0, 8'h45, 1, 3'h5, 0, 3'h0}, '{1, 8'h57, 0, 3'h0, 1, 3'h7},
    '{2, 8'h40, 0, 3'h0, 0, 3'h0}, '{3, 8'hcf, 1, 3'h7, 0, 3'h0},
    '{2, 8'h50, 0, 3'h0, 1, 3'h0}, '{0, 8'h41, 1, 3'h1, 0, 3'h0}};

  always #20 mclk = ~mclk;

  imc_mode_ctrl u_dut (.mclk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .capEvent, .intAck, .irqPending, .irqLevel, .dmaTrig, .dmaChan);
  imc_cap_model u_model (.mclk, .rst, .fire, .ackEn, .irqPending, .dmaTrig, .capEvent, .intAck,
    .trigCnt);

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic summarize();
    $display("mismatches %0d of %0d checks", err_total, tests_run);
    if (err_total == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic to(input int n);
    if (n >= 40) begin
      err_total++;
      summarize();
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= 4'h1;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge mclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    s_axi_bready <= 1'b0;
    chk("bresp", er, s_axi_bresp);
    to(n);
  endtask

  task automatic rd(input logic [5:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge mclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    s_axi_rready <= 1'b0;
    chk("rdata", ed, s_axi_rdata);
    chk("rresp", er, s_axi_rresp);
    to(n);
  endtask

  // Pulses one source for the given cycles and lets the outcome settle.
  task automatic pulse(input int s, input int len);
    c = trigCnt;
    @(posedge mclk);
    fire[s] <= 1'b1;
    repeat (len) @(posedge mclk);
    fire[s] <= 1'b0;
    repeat (3) @(posedge mclk);
    #1;
  endtask

  initial begin
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    for (int k = 0; k < 8; k++) rd(6'(4 * k), 32'h0, 2'h0);
    foreach (rows[i]) begin
      r = rows[i];
      wr(6'(16 + 4 * r.s), r.d, 2'h0);
      rd(6'(16 + 4 * r.s), {24'h0, r.d & 8'h77}, 2'h0);
      pulse(r.s, 1);
      chk("pending", 32'(r.pend) << r.s, irqPending);
      chk("level", r.lvl, irqLevel[r.s]);
      chk("trig", r.trig, trigCnt - c);
      if (r.trig != 0) chk("chan", r.ch, dmaChan[r.s]);
      @(posedge mclk);
      ackEn <= 1'b1;
      repeat (3) @(posedge mclk);
      ackEn <= 1'b0;
    end
    chk("acked", 4'h0, irqPending);
    rd(6'h20, 32'h00000690, 2'h0);
    pulse(1, 3);
    chk("held trig", 1, trigCnt - c);
    wr(6'h04, 8'h00, 2'h0);
    rd(6'h04, 32'h0, 2'h0);
    wr(6'h24, 8'h01, 2'h3);
    rd(6'h24, 32'h0, 2'h3);
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    rd(6'h14, 32'h0, 2'h0);
    chk("reset level", 12'h000, irqLevel);
    summarize();
  end
endmodule
